// ==== tsc_cfg.svh ====
// Purpose: Constants of the TV sound two-wire control port
// Assumes: 50 MHz system clock, 8-bit command registers
// Notes: Offsets are subaddresses as seen on the serial bus
`ifndef TSC_CFG_SVH
`define TSC_CFG_SVH

// Fixed upper five bits of the slave address
`define TSC_ADDR_HI 5'h16
// Fastest serial bit rate served, in kbit/s
`define TSC_MAX_KBPS 400
// System clock rate in kHz
`define TSC_CLK_KHZ 50000
// Least system clocks per serial bit, derived from the two rates
`define TSC_BIT_CYC (`TSC_CLK_KHZ / `TSC_MAX_KBPS)

// Register count and special subaddresses
`define TSC_NUM_REGS 26
`define TSC_SUB_LAST 9'h019
`define TSC_SUB_SETUP 9'h0ff
`define TSC_SUB_GCONF 5'h01
`define TSC_SUB_C1_MS 9'h003
`define TSC_SUB_C1_MID 9'h004
`define TSC_SUB_C1_LS 9'h005
`define TSC_SUB_C2_MS 9'h006
`define TSC_SUB_C2_MID 9'h007
`define TSC_SUB_C2_LS 9'h008
`define TSC_SUB_DEMOD 5'h09
`define TSC_SUB_DEEMPH 5'h0a
`define TSC_SUB_LVL_C1 9'h00c
`define TSC_SUB_LVL_C2 9'h00d
`define TSC_SUB_LVL_NIC 9'h00f
`define TSC_SUB_LVL_DAI 9'h017
`define TSC_SUB_LOW_ERR 5'h10
`define TSC_SUB_UP_ERR 5'h11
`define TSC_SUB_MUTE 5'h12

// Field position and illegal level value
`define TSC_STBY_BIT 5
`define TSC_LVL_ILLEGAL 5'h10

// Power-up values
`define TSC_RST_ZERO 8'h00
`define TSC_RST_MUTE 8'hff
`define TSC_RST_LOW_ERR 8'h14
`define TSC_RST_UP_ERR 8'h50
`define TSC_RST_DEEMPH 8'h00

`endif

// ==== tsc_pkg.sv ====
// Purpose: Types of the TV sound two-wire control port
// Assumes: Nothing beyond the constants header
// Notes: Holds the receive state machine encoding
package tsc_pkg;
    // Receive sequencer states
    typedef enum logic [2:0] {
        TSC_IDLE     = 3'h0,
        TSC_ADDR     = 3'h1,
        TSC_ADDR_ACK = 3'h2,
        TSC_SUB      = 3'h3,
        TSC_SUB_ACK  = 3'h4,
        TSC_DATA     = 3'h5,
        TSC_DATA_ACK = 3'h6,
        TSC_IGNORE   = 3'h7
    } tsc_state_t;
endpackage

// ==== tsc_sync.sv ====
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous levels
// Notes: First stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module tsc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_reg; // First stage, may go metastable
    logic [WIDTH-1:0] q_reg; // Second stage, safe to use

    // Idle value high suits the pulled-up bus lines
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            meta_reg <= '1;
            q_reg <= '1;
        end else begin
            meta_reg <= d_i;
            q_reg <= meta_reg;
        end
    end

    assign q_o = q_reg;
endmodule
`default_nettype wire

// ==== tsc_ctrl_port.sv ====
// Purpose: Two-wire slave receiver and command register file
// Assumes: Host is bus master; no clock stretching is done
// Notes: The contract below lists the rules this module keeps
// Contract
// - Answer 10110 plus two address-select pins
// - Serve fast-mode bit rates up to 400k
// - Never acknowledge the general call address
// - Slave stays alive during standby
// - Twenty-six subaddressed command registers
// - Subaddress increments after each data byte
// - Start anywhere valid; ack stored bytes
// - Nack nonexistent subaddress; never wrap
// - Multi-byte functions apply after last byte
// - Stop before last byte discards partial function
// - Store unchecked except level-adjust registers
// - Stop without ack is bus error
// - Power-up: muted, no carrier, outputs off
// - Power-up: IF input one, AGC, FM defaults
// - Setup byte overwrites subaddresses 3 to 10
`timescale 1ns/1ps
`default_nettype none
`include "tsc_cfg.svh"
module tsc_ctrl_port
    import tsc_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic slave_addr_select_bit0_i,
    input wire logic slave_addr_select_bit1_i,
    input wire logic [23:0] setup_c1_freq_i,
    input wire logic [23:0] setup_c2_freq_i,
    input wire logic [7:0] setup_demod_i,
    input wire logic [7:0] setup_deemph_i,
    output logic [207:0] regs_o,
    output logic [7:0] easy_standard_setup_o,
    output logic standby_o,
    output logic freq1_load_o,
    output logic freq2_load_o,
    output logic bus_error_o
);
    logic [3:0] pins_s; // Synchronised scl, sda, selects
    logic scl_s, sda_s;
    logic scl_d_reg, sda_d_reg, scl_d_next, sda_d_next; // Previous line levels
    logic start_c, stop_c, rise_c, fall_c; // Bus events
    tsc_state_t state_reg, state_next;
    logic [3:0] bit_reg, bit_next; // Bits shifted this byte
    logic [7:0] sh_reg, sh_next; // Receive shifter
    logic [8:0] ptr_reg, ptr_next; // Subaddress pointer, 9 bits so 255 never wraps
    logic oe_reg, oe_next; // Pulling sda low
    logic berr_reg, berr_next;
    logic commit_c; // Data byte acknowledged and complete
    logic ptr_ok_c, lvl_bad_c, addr_hit_c;
    logic [7:0] regs_reg [0:`TSC_NUM_REGS-1];
    logic [7:0] regs_next [0:`TSC_NUM_REGS-1];
    logic [7:0] stage_reg [0:5]; // Carrier bytes held until complete
    logic [7:0] stage_next [0:5];
    logic [5:0] mask_reg, mask_next; // Which staged bytes are present
    logic [7:0] setup_reg, setup_next; // Last standard setup byte
    logic preset_reg, preset_next; // Preset load pending
    logic f1_reg, f1_next, f2_reg, f2_next;

    // Line synchroniser, one instance for all pins
    tsc_sync #(.WIDTH(4)) u_sync (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .d_i({slave_addr_select_bit1_i, slave_addr_select_bit0_i, sda_i, scl_i}),
        .q_o(pins_s)
    );
    assign scl_s = pins_s[0];
    assign sda_s = pins_s[1];

    // Start/stop are sda edges with scl high
    // Sampling at 50 MHz leaves over a hundred clocks per 400k bit
    assign start_c = scl_d_reg && scl_s && sda_d_reg && !sda_s;
    assign stop_c = scl_d_reg && scl_s && !sda_d_reg && sda_s;
    assign rise_c = !scl_d_reg && scl_s;
    assign fall_c = scl_d_reg && !scl_s;

    // Address match; zero address can never hit
    assign addr_hit_c = (sh_reg == {`TSC_ADDR_HI, pins_s[3:2], 1'b0});
    // Valid subaddresses: 0..25 and 255
    assign ptr_ok_c = (ptr_reg <= `TSC_SUB_LAST) || (ptr_reg == `TSC_SUB_SETUP);
    // Level-adjust bytes are the only ones checked
    assign lvl_bad_c = ((ptr_reg == `TSC_SUB_LVL_C1) || (ptr_reg == `TSC_SUB_LVL_C2) ||
                        (ptr_reg == `TSC_SUB_LVL_NIC) || (ptr_reg == `TSC_SUB_LVL_DAI)) &&
                       ((sh_reg[7:5] != 3'h0) || (sh_reg[4:0] == `TSC_LVL_ILLEGAL));
    // Commit only once the ack bit has completed
    assign commit_c = (state_reg == TSC_DATA_ACK) && fall_c;

    // Receive sequencer next state
    always_comb begin
        state_next = state_reg;
        bit_next = bit_reg;
        sh_next = sh_reg;
        ptr_next = ptr_reg;
        oe_next = oe_reg;
        berr_next = 1'b0;
        scl_d_next = scl_s;
        sda_d_next = sda_s;
        if (stop_c) begin
            // Stop mid-byte drops the byte in flight
            // A normal stop follows one high clock of the next byte, so that is no error
            if ((state_reg == TSC_ADDR || state_reg == TSC_SUB ||
                 state_reg == TSC_DATA) && bit_reg > 4'h1) begin
                berr_next = 1'b1;
            end
            state_next = TSC_IDLE;
            oe_next = 1'b0;
        end else if (start_c) begin
            // Start or repeated start begins a new address phase
            state_next = TSC_ADDR;
            bit_next = 4'h0;
            oe_next = 1'b0;
        end else if (rise_c && (state_reg == TSC_ADDR || state_reg == TSC_SUB ||
                                state_reg == TSC_DATA)) begin
            // Sample data while clock is high
            sh_next = {sh_reg[6:0], sda_s};
            bit_next = bit_reg + 4'h1;
        end else if (fall_c) begin
            unique case (state_reg)
                TSC_ADDR: begin
                    // Write direction only; reads are not answered
                    if (bit_reg == 4'h8) begin
                        state_next = addr_hit_c ? TSC_ADDR_ACK : TSC_IGNORE;
                        oe_next = addr_hit_c;
                    end
                end
                TSC_SUB: begin
                    if (bit_reg == 4'h8) begin
                        state_next = TSC_SUB_ACK;
                        oe_next = 1'b1;
                    end
                end
                TSC_DATA: begin
                    if (bit_reg == 4'h8) begin
                        // Nack bad pointer or illegal level
                        state_next = (ptr_ok_c && !lvl_bad_c) ? TSC_DATA_ACK : TSC_IGNORE;
                        oe_next = ptr_ok_c && !lvl_bad_c;
                    end
                end
                TSC_ADDR_ACK: begin
                    state_next = TSC_SUB;
                    bit_next = 4'h0;
                    oe_next = 1'b0;
                end
                TSC_SUB_ACK: begin
                    // Any valid subaddress may start a write
                    state_next = TSC_DATA;
                    ptr_next = {1'b0, sh_reg};
                    bit_next = 4'h0;
                    oe_next = 1'b0;
                end
                TSC_DATA_ACK: begin
                    // Advance pointer; 255 moves to 256, no wrap
                    state_next = TSC_DATA;
                    ptr_next = ptr_reg + 9'h001;
                    bit_next = 4'h0;
                    oe_next = 1'b0;
                end
                TSC_IDLE, TSC_IGNORE: begin
                    state_next = state_reg;
                end
            endcase
        end
    end

    // Receive sequencer registers; standby never touches them
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            state_reg <= TSC_IDLE;
            bit_reg <= 4'h0;
            sh_reg <= 8'h00;
            ptr_reg <= 9'h000;
            oe_reg <= 1'b0;
            berr_reg <= 1'b0;
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            bit_reg <= bit_next;
            sh_reg <= sh_next;
            ptr_reg <= ptr_next;
            oe_reg <= oe_next;
            berr_reg <= berr_next;
            scl_d_reg <= scl_d_next;
            sda_d_reg <= sda_d_next;
        end
    end

    // Register file next values
    always_comb begin
        for (int i = 0; i < `TSC_NUM_REGS; i++) begin
            regs_next[i] = regs_reg[i];
        end
        for (int i = 0; i < 6; i++) begin
            stage_next[i] = stage_reg[i];
        end
        mask_next = mask_reg;
        setup_next = setup_reg;
        preset_next = 1'b0;
        f1_next = 1'b0;
        f2_next = 1'b0;
        // Preset lands one clock after the setup byte
        if (preset_reg) begin
            {regs_next[3], regs_next[4], regs_next[5]} = setup_c1_freq_i;
            {regs_next[6], regs_next[7], regs_next[8]} = setup_c2_freq_i;
            regs_next[`TSC_SUB_DEMOD] = {setup_reg[5:4], setup_demod_i[5], setup_reg[7],
                                         setup_demod_i[3:2], setup_reg[6], setup_demod_i[0]};
            regs_next[`TSC_SUB_DEEMPH] = setup_deemph_i;
            f1_next = 1'b1;
            f2_next = 1'b1;
        end
        if (commit_c) begin
            // Carrier words are staged, then applied whole
            if (ptr_reg >= `TSC_SUB_C1_MS && ptr_reg <= `TSC_SUB_C2_LS) begin
                stage_next[ptr_reg[2:0] - 3'h3] = sh_reg;
                mask_next[ptr_reg[2:0] - 3'h3] = 1'b1;
            end
            if (ptr_reg == `TSC_SUB_C1_LS && mask_reg[1:0] == 2'h3) begin
                regs_next[3] = stage_reg[0];
                regs_next[4] = stage_reg[1];
                regs_next[5] = sh_reg;
                f1_next = 1'b1;
            end else if (ptr_reg == `TSC_SUB_C2_LS && mask_reg[4:3] == 2'h3) begin
                regs_next[6] = stage_reg[3];
                regs_next[7] = stage_reg[4];
                regs_next[8] = sh_reg;
                f2_next = 1'b1;
            end else if (ptr_reg == `TSC_SUB_SETUP) begin
                setup_next = sh_reg;
                preset_next = 1'b1;
            end else if (ptr_reg <= `TSC_SUB_LAST && (ptr_reg < `TSC_SUB_C1_MS ||
                                                     ptr_reg > `TSC_SUB_C2_LS)) begin
                // Single-byte registers stored as sent
                regs_next[ptr_reg[4:0]] = sh_reg;
            end
        end
        // Transfer end drops incomplete carrier words
        if (stop_c || start_c) begin
            mask_next = 6'h00;
        end
    end

    // Register file storage with power-up state
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < `TSC_NUM_REGS; i++) begin
                regs_reg[i] <= `TSC_RST_ZERO; // IF input one, AGC on, FM, no carrier
            end
            regs_reg[`TSC_SUB_MUTE] <= `TSC_RST_MUTE; // All outputs muted
            regs_reg[`TSC_SUB_LOW_ERR] <= `TSC_RST_LOW_ERR;
            regs_reg[`TSC_SUB_UP_ERR] <= `TSC_RST_UP_ERR;
            regs_reg[`TSC_SUB_DEEMPH] <= `TSC_RST_DEEMPH; // 50 us, adaptive off
            for (int i = 0; i < 6; i++) begin
                stage_reg[i] <= 8'h00;
            end
            mask_reg <= 6'h00;
            setup_reg <= 8'h00;
            preset_reg <= 1'b0;
            f1_reg <= 1'b0;
            f2_reg <= 1'b0;
        end else begin
            regs_reg <= regs_next;
            stage_reg <= stage_next;
            mask_reg <= mask_next;
            setup_reg <= setup_next;
            preset_reg <= preset_next;
            f1_reg <= f1_next;
            f2_reg <= f2_next;
        end
    end

    // Flatten register file, subaddress 0 in the low byte
    for (genvar g = 0; g < `TSC_NUM_REGS; g++) begin : g_flat
        assign regs_o[g*8 +: 8] = regs_reg[g];
    end
    assign sda_o = 1'b0; // Open drain: only ever pulls low
    assign sda_oe_o = oe_reg;
    assign easy_standard_setup_o = setup_reg;
    assign standby_o = regs_reg[`TSC_SUB_GCONF][`TSC_STBY_BIT];
    assign freq1_load_o = f1_reg;
    assign freq2_load_o = f2_reg;
    assign bus_error_o = berr_reg;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    property p_addr_ack;
        (state_reg == TSC_ADDR && bit_reg == 4'h8 && fall_c && !start_c && !stop_c &&
         sh_reg == {`TSC_ADDR_HI, pins_s[3:2], 1'b0}) |=> (oe_reg && state_reg == TSC_ADDR_ACK);
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("Own address not acked");
    property p_gen_call;
        (state_reg == TSC_ADDR && bit_reg == 4'h8 && fall_c && sh_reg == 8'h00) |=> !oe_reg;
    endproperty
    a_gen_call: assert property (p_gen_call) else $error("General call acked");
    property p_nack_bad;
        (state_reg == TSC_DATA && bit_reg == 4'h8 && fall_c && !ptr_ok_c) |=>
            (!oe_reg [*2]);
    endproperty
    a_nack_bad: assert property (p_nack_bad) else $error("Bad subaddress acked");
    property p_lvl;
        (state_reg == TSC_DATA && bit_reg == 4'h8 && fall_c && lvl_bad_c) |=>
            (state_reg == TSC_IGNORE && !oe_reg);
    endproperty
    a_lvl: assert property (p_lvl) else $error("Illegal level accepted");
    property p_incr;
        commit_c && !stop_c && !start_c |=> (ptr_reg == $past(ptr_reg) + 9'h001);
    endproperty
    a_incr: assert property (p_incr) else $error("Pointer did not advance");
    property p_berr;
        (stop_c && state_reg == TSC_DATA && bit_reg > 4'h1) |=>
            (bus_error_o ##1 !bus_error_o);
    endproperty
    a_berr: assert property (p_berr) else $error("Bus error not flagged");
    property p_partial;
        stop_c |=> (mask_reg == 6'h00) ##1 !freq1_load_o;
    endproperty
    a_partial: assert property (p_partial) else $error("Partial word kept");
    property p_c1_whole;
        (commit_c && ptr_reg == `TSC_SUB_C1_LS && mask_reg[1:0] == 2'h3) |=>
            (freq1_load_o && regs_reg[5] == $past(sh_reg));
    endproperty
    a_c1_whole: assert property (p_c1_whole) else $error("Carrier 1 not applied");
    property p_setup;
        (commit_c && ptr_reg == `TSC_SUB_SETUP) |=> ##1
            (freq1_load_o && freq2_load_o && regs_reg[3] == setup_c1_freq_i[23:16]);
    endproperty
    a_setup: assert property (p_setup) else $error("Setup preset not loaded");

    c_write: cover property (commit_c && ptr_reg == `TSC_SUB_LAST);
    c_setup: cover property (preset_reg);
    c_berr: cover property (bus_error_o);
    c_f2: cover property (freq2_load_o && !preset_reg);
endmodule
`default_nettype wire

// ==== tsc_host_model.sv ====
// Purpose: Two-wire bus master standing in for the host controller
// Assumes: Open-drain bus with pull-ups; sda_o high means released
// Notes: Timing counted in system clock falling edges
`timescale 1ns/1ps
`default_nettype none
module tsc_host_model (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o,
    output logic ack_stb_o,
    output logic ack_o
);
    // Half bit period; 63 cycles stays under 400 kbit/s, raise it for a slow host
    int half = 63;
    // Both lines released at time zero, so the pull-ups hold them high
    initial begin
        scl_o = 1'h1;
        sda_o = 1'h1;
        ack_stb_o = 1'h0;
        ack_o = 1'h0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // Start, also good as a repeated start
    task automatic start();
        tick(4);
        sda_o = 1'h1;
        tick(half);
        scl_o = 1'h1;
        tick(half);
        sda_o = 1'h0;
        tick(half);
        scl_o = 1'h0;
    endtask
    // Data moves only with the clock low, 4 cycles after its fall for hold
    task automatic bit_out(input logic b);
        tick(4);
        sda_o = b;
        tick(half - 4);
        scl_o = 1'h1;
        tick(half);
        scl_o = 1'h0;
    endtask
    // Byte then ninth clock; answer sampled mid-high and flagged for one cycle
    task automatic put(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            bit_out(b[i]);
        end
        tick(4);
        sda_o = 1'h1;
        tick(half - 4);
        scl_o = 1'h1;
        tick(half / 2);
        ack_o = ~sda_i;
        ack_stb_o = 1'h1;
        tick(1);
        ack_stb_o = 1'h0;
        tick(half - half / 2 - 1);
        scl_o = 1'h0;
    endtask
    // Stop: data rises while the clock is high
    task automatic stop();
        tick(4);
        sda_o = 1'h0;
        tick(half - 4);
        scl_o = 1'h1;
        tick(half);
        sda_o = 1'h1;
        tick(half);
    endtask
endmodule
`default_nettype wire

// ==== tsc_ctrl_port_test.sv ====
// Purpose: Self-checking bench of the two-wire control port
// Assumes: Host model drives the bus; pull-up on the data line
// Notes: Acknowledge answers are checked through a queue of notes
`timescale 1ns/1ps
`default_nettype none
module tsc_ctrl_port_test;
    logic clk, nrst, a0, a1, sby, f1, f2, berr, dut_sda, sda_oe;
    logic hs_scl, hs_sda, ack_stb, ack, ok;
    logic [23:0] c1f, c2f;
    logic [7:0] dm, de, dev, d, e, setup;
    logic [207:0] regs;
    wire sda_bus;
    // Mirror of the register file, kept from the rules alone
    logic [7:0] m [0:25];
    logic exp_q [$];
    logic [7:0] lv [0:2] = '{8'h10, 8'h30, 8'h1f};
    int n_errors = 0, checked = 0, n_f1 = 0, n_f2 = 0, n_be = 0;
    // Open drain: released line reads high through the pull-up
    assign sda_bus = hs_sda & (sda_oe ? dut_sda : 1'h1);
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end
    tsc_ctrl_port tsc_ctrl_port_inst (.clk_i(clk), .nrst_i(nrst), .scl_i(hs_scl),
        .sda_i(sda_bus), .sda_o(dut_sda), .sda_oe_o(sda_oe), .slave_addr_select_bit0_i(a0),
        .slave_addr_select_bit1_i(a1), .setup_c1_freq_i(c1f), .setup_c2_freq_i(c2f),
        .setup_demod_i(dm), .setup_deemph_i(de), .regs_o(regs), .easy_standard_setup_o(setup),
        .standby_o(sby), .freq1_load_o(f1), .freq2_load_o(f2), .bus_error_o(berr));
    tsc_host_model tsc_host_model_inst (.clk_i(clk), .sda_i(sda_bus), .scl_o(hs_scl),
        .sda_o(hs_sda), .ack_stb_o(ack_stb), .ack_o(ack));
    task automatic fail(input string s);
        n_errors++;
        $display("[FAIL] %0t %s", $time, s);
    endtask
    task automatic chk(input logic c, input string s);
        checked++;
        if (c !== 1'h1) begin
            fail(s);
        end
    endtask
    task automatic chk_regs();
        for (int i = 0; i < 26; i++) begin
            chk(regs[8*i +: 8] === m[i], "register file content");
        end
    endtask
    // Note the expected answer, then clock the byte out
    task automatic send(input logic [7:0] b, input logic a);
        exp_q.push_back(a);
        tsc_host_model_inst.put(b);
    endtask
    task automatic open_tx(input logic [7:0] sub);
        tsc_host_model_inst.start();
        send(dev, 1'h1);
        send(sub, 1'h1);
    endtask
    task automatic fin();
        tsc_host_model_inst.stop();
    endtask
    function automatic logic lvl(input int p);
        return p == 12 || p == 13 || p == 15 || p == 23;
    endfunction
    // Random bytes to successive subaddresses; level bytes kept legal
    task automatic burst(input int first, input int last);
        open_tx(first[7:0]);
        for (int p = first; p <= last; p++) begin
            d = 8'($urandom);
            if (lvl(p)) begin
                d = d & 8'h0f;
            end
            send(d, p < 26);
            if (p < 26) begin
                m[p] = d;
            end
        end
        fin();
    endtask
    task automatic close_out();
        if (n_errors == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Take the oldest note whenever an answer slot appears; count pulses
    always @(posedge clk) begin
        if (ack_stb === 1'h1) begin
            if (exp_q.size() == 0) begin
                fail("answer slot not expected");
            end else begin
                checked++;
                if (ack !== exp_q.pop_front()) begin
                    fail("acknowledge answer wrong");
                end
            end
        end
        if (nrst === 1'h1 && f1 === 1'h1) n_f1++;
        if (nrst === 1'h1 && f2 === 1'h1) n_f2++;
        if (nrst === 1'h1 && berr === 1'h1) n_be++;
    end
    // Watchdog, about a third beyond the expected run length
    initial begin
        #2_500_000;
        n_errors++;
        close_out();
    end
    initial begin
        {nrst, a0, a1, c1f, c2f, dm, de} = '0;
        dev = 8'hb0;
        void'($urandom(32'hd9cc));
        for (int i = 0; i < 26; i++) begin
            m[i] = 8'h00;
        end
        m[16] = 8'h14;
        m[17] = 8'h50;
        m[18] = 8'hff;
        repeat (6) @(negedge clk);
        nrst = 1'h1;
        repeat (4) @(negedge clk);
        chk_regs();
        chk(setup === 8'h00 && sda_oe === 1'h0 && sby === 1'h0, "power-up state");
        // Every select pin setting answers its own address
        for (int s = 0; s < 4; s++) begin
            {a1, a0} = s[1:0];
            dev = {5'h16, s[1:0], 1'h0};
            d = 8'($urandom);
            open_tx(8'h00);
            send(d, 1'h1);
            fin();
            m[0] = d;
        end
        tsc_host_model_inst.start();
        send(dev ^ 8'h02, 1'h0);
        tsc_host_model_inst.start();
        send(8'h00, 1'h0);
        tsc_host_model_inst.start();
        send(dev | 8'h01, 1'h0);
        fin();
        chk_regs();
        burst(12, 26);
        chk_regs();
        // Standby keeps the slave alive; host then reprograms
        open_tx(8'h01);
        send(8'h20, 1'h1);
        fin();
        m[1] = 8'h20;
        chk(sby === 1'h1, "standby flag");
        burst(12, 13);
        open_tx(8'h01);
        send(8'h00, 1'h1);
        fin();
        m[1] = 8'h00;
        chk(sby === 1'h0, "standby left");
        // Level bytes are checked: out of range refused and not stored
        for (int i = 0; i < 3; i++) begin
            ok = lv[i][7:5] == 3'h0 && lv[i][4:0] != 5'h10;
            open_tx(8'h0f);
            send(lv[i], ok);
            fin();
            if (ok) m[15] = lv[i];
        end
        chk_regs();
        // Carrier word cut short, then last byte alone: both discarded
        open_tx(8'h03);
        send(8'($urandom), 1'h1);
        send(8'($urandom), 1'h1);
        fin();
        open_tx(8'h05);
        send(8'($urandom), 1'h1);
        fin();
        chk_regs();
        chk(n_f1 === 0 && n_f2 === 0, "no carrier load yet");
        burst(3, 8);
        chk_regs();
        chk(n_f1 === 1 && n_f2 === 1, "carrier words applied once");
        // Slow host; stop in mid-byte is a bus error and nothing stored
        tsc_host_model_inst.half = 150;
        open_tx(8'h00);
        for (int i = 0; i < 3; i++) begin
            tsc_host_model_inst.bit_out(1'($urandom));
        end
        fin();
        tsc_host_model_inst.half = 63;
        chk(n_be === 1, "bus error pulse");
        chk_regs();
        // Standard setup byte reloads subaddresses 3 to 10; no wrap past it
        c1f = 24'($urandom);
        c2f = 24'($urandom);
        dm = 8'($urandom);
        de = 8'($urandom);
        e = 8'($urandom);
        open_tx(8'hff);
        send(e, 1'h1);
        send(8'($urandom), 1'h0);
        fin();
        {m[3], m[4], m[5], m[6], m[7], m[8]} = {c1f, c2f};
        m[9] = dm;
        {m[9][7], m[9][6], m[9][4], m[9][1]} = {e[5], e[4], e[7], e[6]};
        m[10] = de;
        chk(setup === e, "setup byte kept");
        chk_regs();
        chk(n_f1 === 2 && n_f2 === 2, "setup loads both carriers");
        chk(exp_q.size() == 0, "answers missing");
        close_out();
    end
endmodule
`default_nettype wire
